//--- src/fsl_pkg.sv
// Package: register map, field layout, timing and state types of the fault and lamp block
package fsl_pkg;
	// Byte addresses on the Avalon-MM register bus
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_ERRCODE = 4'h8;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'hc;
	localparam logic [3:0] ADDR_IRQ_CLR = 4'h0;
	localparam logic [3:0] ADDR_IRQ_CLR_W = 4'h0;
	localparam logic [5:0] ADDR_IRQ_CLEAR = 6'h10;
	localparam logic [5:0] ADDR_IRQ_EN = 6'h14;
	localparam logic [5:0] ADDR_HIST0 = 6'h20;
	localparam logic [5:0] ADDR_BUS_MASK = 6'h3c;

	// Control register fields
	localparam int CTRL_LAMP_OFF = 0;
	localparam int CTRL_FAULT_RESET = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Status register fields
	localparam int STAT_ERROR = 0;
	localparam int STAT_STAGE_EN = 1;
	localparam int STAT_HOT = 2;
	localparam int STAT_CLASS_LSB = 4;

	// Event bits of the interrupt status register
	localparam int EV_FAULT = 0;
	localparam int EV_CLEARED = 1;
	localparam int EV_WIDTH = 2;

	// Error classes, value equals the number of red blinks per group
	localparam logic [2:0] CLS_NONE = 3'h0;
	localparam logic [2:0] CLS_GENERAL = 3'h1;
	localparam logic [2:0] CLS_VOLTAGE = 3'h2;
	localparam logic [2:0] CLS_TEMP = 3'h3;
	localparam logic [2:0] CLS_OVERCURRENT = 3'h4;
	localparam logic [2:0] CLS_CONTROLLER = 3'h5;
	localparam logic [2:0] CLS_WATCHDOG = 3'h6;

	// Detailed error code layout and history depth
	localparam int CODE_W = 16;
	localparam int HIST_DEPTH = 4;
	localparam logic [15:0] CODE_OVERTEMP = 16'h4310;

	// Timing, each figure in ms, converted to cycles at 100 MHz
	localparam int CLK_KHZ = 100000;
	localparam int T_PERIOD_MS = 1000;
	localparam int T_GREEN_MS = 100;
	localparam int T_RED_ON_MS = 200;
	localparam int T_RED_GAP_MS = 300;
	localparam int T_GROUP_PAUSE_MS = 1500;
	localparam int CYC_PERIOD = T_PERIOD_MS * CLK_KHZ;
	localparam int CYC_GREEN = T_GREEN_MS * CLK_KHZ;
	localparam int CYC_RED_ON = T_RED_ON_MS * CLK_KHZ;
	localparam int CYC_RED_GAP = T_RED_GAP_MS * CLK_KHZ;
	localparam int CYC_GROUP_PAUSE = T_GROUP_PAUSE_MS * CLK_KHZ;

	typedef struct packed {
		logic green;
		logic red;
	} fsl_lamp_t;

	typedef struct packed {
		logic valid;
		logic [2:0] cls;
		logic [15:0] code;
	} fsl_fault_t;

	typedef enum logic [3:0] {
		LS_GREEN_ON = 4'h1,
		LS_GREEN_OFF = 4'h2,
		LS_RED_ON = 4'h4,
		LS_RED_OFF = 4'h8
	} fsl_lamp_state_t;
endpackage

//--- src/fsl_lamp.sv
// Lamp sequencer: green heartbeat or red blink groups counting the error class
`timescale 1ns/1ps
module fsl_lamp #(
	parameter int PERIOD = fsl_pkg::CYC_PERIOD,
	parameter int GREEN = fsl_pkg::CYC_GREEN,
	parameter int RED_ON = fsl_pkg::CYC_RED_ON,
	parameter int RED_GAP = fsl_pkg::CYC_RED_GAP,
	parameter int PAUSE = fsl_pkg::CYC_GROUP_PAUSE
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic lamp_off,
	input wire logic [2:0] err_class,
	output fsl_pkg::fsl_lamp_t status_lamp
);
	fsl_pkg::fsl_lamp_state_t state;
	fsl_pkg::fsl_lamp_state_t next_state;
	logic [31:0] timer;
	logic [2:0] blinks;
	logic in_error;
	logic timer_done;
	logic last_blink;
	logic [31:0] reload;
	fsl_pkg::fsl_lamp_t next_lamp;

	assign in_error = (err_class != fsl_pkg::CLS_NONE);
	assign timer_done = (timer == 32'h0000_0001);
	assign last_blink = (blinks >= err_class);

	always_comb begin
		next_state = state;
		reload = timer - 32'h0000_0001;
		case (state)
			fsl_pkg::LS_GREEN_ON: begin
				if (in_error) begin
					next_state = fsl_pkg::LS_RED_OFF;
					reload = 32'(PAUSE);
				end else if (timer_done) begin
					next_state = fsl_pkg::LS_GREEN_OFF;
					reload = 32'(PERIOD - GREEN);
				end
			end
			fsl_pkg::LS_GREEN_OFF: begin
				if (in_error) begin
					next_state = fsl_pkg::LS_RED_ON;
					reload = 32'(RED_ON);
				end else if (timer_done) begin
					next_state = fsl_pkg::LS_GREEN_ON;
					reload = 32'(GREEN);
				end
			end
			fsl_pkg::LS_RED_ON: begin
				if (timer_done) begin
					next_state = fsl_pkg::LS_RED_OFF;
					// Long dark pause after the last blink separates groups
					reload = last_blink ? 32'(PAUSE) : 32'(RED_GAP);
				end
			end
			fsl_pkg::LS_RED_OFF: begin
				if (!in_error) begin
					next_state = fsl_pkg::LS_GREEN_ON;
					reload = 32'(GREEN);
				end else if (timer_done) begin
					next_state = fsl_pkg::LS_RED_ON;
					reload = 32'(RED_ON);
				end
			end
			default: begin
				next_state = fsl_pkg::LS_GREEN_ON;
				reload = 32'(GREEN);
			end
		endcase
	end

	always_comb begin
		next_lamp.green = (next_state == fsl_pkg::LS_GREEN_ON) && !lamp_off;
		next_lamp.red = (next_state == fsl_pkg::LS_RED_ON) && !lamp_off;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= fsl_pkg::LS_GREEN_OFF;
			timer <= 32'(GREEN);
			blinks <= 3'h0;
			status_lamp <= '0;
		end else if (clk_en) begin
			state <= next_state;
			timer <= reload;
			status_lamp <= next_lamp;
			if (state == fsl_pkg::LS_RED_ON && timer_done) begin
				blinks <= last_blink ? 3'h0 : blinks + 3'h1;
			end else if (!in_error) begin
				blinks <= 3'h1;
			end else if (state == fsl_pkg::LS_GREEN_OFF || state == fsl_pkg::LS_GREEN_ON) begin
				blinks <= 3'h1;
			end else if (blinks == 3'h0) begin
				blinks <= 3'h1;
			end
		end
	end

	AST_LAMP_OFF_DARK: assert property (@(posedge clk) disable iff (reset)
		clk_en && lamp_off |=> (status_lamp == '0))
		else $error("lamp lit while switched off");
	AST_NO_RED_NORMAL: assert property (@(posedge clk) disable iff (reset)
		clk_en && !in_error && state != fsl_pkg::LS_RED_ON |=> !status_lamp.red)
		else $error("red lamp without an error");
	AST_NO_GREEN_ERR: assert property (@(posedge clk) disable iff (reset)
		$stable(err_class) && in_error && state == fsl_pkg::LS_RED_OFF && clk_en
		|=> !status_lamp.green)
		else $error("green lamp during an error");
	AST_PAUSE_LONG: assert property (@(posedge clk) disable iff (reset)
		state == fsl_pkg::LS_RED_ON && timer_done && last_blink && clk_en
		|=> timer == 32'(PAUSE))
		else $error("group pause not loaded");
	AST_BLINK_LIMIT: assert property (@(posedge clk) disable iff (reset)
		in_error |-> blinks <= err_class || blinks == 3'h1)
		else $error("blink count beyond error class");
endmodule

//--- src/fsl_top.sv
// Fault supervision with power stage cut-off, error history and status lamp
`timescale 1ns/1ps
module fsl_top #(
	// Lamp timings in cycles; a bench may shorten them to see whole groups
	parameter int PERIOD = fsl_pkg::CYC_PERIOD,
	parameter int GREEN = fsl_pkg::CYC_GREEN,
	parameter int RED_ON = fsl_pkg::CYC_RED_ON,
	parameter int RED_GAP = fsl_pkg::CYC_RED_GAP,
	parameter int PAUSE = fsl_pkg::CYC_GROUP_PAUSE
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic over_temp,
	input wire logic fault_in,
	input wire logic [2:0] fault_class,
	input wire logic [15:0] fault_code,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic stage_enable,
	output logic irq,
	output fsl_pkg::fsl_lamp_t status_lamp
);
	logic [31:0] ctrl;
	fsl_pkg::fsl_fault_t fault;
	logic [15:0] history [fsl_pkg::HIST_DEPTH];
	logic [1:0] hist_ptr;
	logic [fsl_pkg::EV_WIDTH-1:0] irq_stat;
	logic [fsl_pkg::EV_WIDTH-1:0] irq_en;
	logic ack;
	logic hot_q;

	// Bus decode: a single wait cycle, answer on the second edge
	wire logic req = (avs_read | avs_write) & ~ack;
	wire logic wr = avs_write & ~avs_waitrequest;
	wire logic wr_ctrl = wr && avs_address == 6'(fsl_pkg::ADDR_CTRL) && avs_byteenable[0];
	wire logic wr_clr = wr && avs_address == fsl_pkg::ADDR_IRQ_CLEAR && avs_byteenable[0];
	wire logic wr_en = wr && avs_address == fsl_pkg::ADDR_IRQ_EN && avs_byteenable[0];
	wire logic fault_reset_cmd = wr_ctrl && avs_writedata[fsl_pkg::CTRL_FAULT_RESET];

	// Incoming events; overtemperature maps to the temperature class
	wire logic temp_event = over_temp && !fault.valid;
	wire logic ext_event = fault_in && !fault.valid && fault_class != fsl_pkg::CLS_NONE;
	wire logic new_fault = temp_event | ext_event;
	// Clearing is refused while still hot so the stage cannot come back early
	wire logic clear_ok = fault_reset_cmd && fault.valid && !over_temp && !fault_in;
	wire logic [2:0] new_class = temp_event ? fsl_pkg::CLS_TEMP : fault_class;
	wire logic [15:0] new_code = temp_event ? fsl_pkg::CODE_OVERTEMP : fault_code;
	wire logic [fsl_pkg::EV_WIDTH-1:0] ev = {clear_ok, new_fault};

	function automatic logic [31:0] read_mux(input logic [5:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (a)
			6'(fsl_pkg::ADDR_CTRL): d = ctrl;
			6'(fsl_pkg::ADDR_STATUS): d = {25'h0, fault.cls, 1'b0, hot_q, stage_enable, fault.valid};
			6'(fsl_pkg::ADDR_ERRCODE): d = {16'h0, fault.code};
			6'(fsl_pkg::ADDR_IRQ_STAT): d = {30'h0, irq_stat};
			fsl_pkg::ADDR_IRQ_EN: d = {30'h0, irq_en};
			fsl_pkg::ADDR_HIST0: d = {16'h0, history[0]};
			fsl_pkg::ADDR_HIST0 + 6'h04: d = {16'h0, history[1]};
			fsl_pkg::ADDR_HIST0 + 6'h08: d = {16'h0, history[2]};
			fsl_pkg::ADDR_HIST0 + 6'h0c: d = {16'h0, history[3]};
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	always_ff @(posedge clk) begin
		if (reset) begin
			ack <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if (clk_en) begin
			ack <= req;
			avs_waitrequest <= ~req;
			avs_readdata <= req ? read_mux(avs_address) : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl <= fsl_pkg::CTRL_RESET;
			irq_en <= '0;
		end else if (clk_en) begin
			// Fault reset bit is a command, it never reads back as set
			if (wr_ctrl)
				ctrl <= {30'h0, 1'b0, avs_writedata[fsl_pkg::CTRL_LAMP_OFF]};
			if (wr_en)
				irq_en <= avs_writedata[fsl_pkg::EV_WIDTH-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fault <= '0;
			stage_enable <= 1'b0;
			hot_q <= 1'b0;
			hist_ptr <= 2'h0;
			irq_stat <= '0;
			irq <= 1'b0;
		end else if (clk_en) begin
			hot_q <= over_temp;
			if (new_fault) begin
				fault <= '{valid: 1'b1, cls: new_class, code: new_code};
				stage_enable <= 1'b0;
				history[hist_ptr] <= new_code;
				hist_ptr <= hist_ptr + 2'h1;
			end else if (clear_ok) begin
				fault <= '0;
				stage_enable <= 1'b1;
			end else if (!fault.valid) begin
				stage_enable <= 1'b1;
			end
			// Set wins over a clear in the same cycle
			irq_stat <= (irq_stat & ~(wr_clr ? avs_writedata[fsl_pkg::EV_WIDTH-1:0] : '0)) | ev;
			irq <= |(((irq_stat & ~(wr_clr ? avs_writedata[fsl_pkg::EV_WIDTH-1:0] : '0)) | ev)
				& irq_en);
		end
	end

	fsl_lamp #(
		.PERIOD(PERIOD),
		.GREEN(GREEN),
		.RED_ON(RED_ON),
		.RED_GAP(RED_GAP),
		.PAUSE(PAUSE)
	) u_lamp (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.lamp_off(ctrl[fsl_pkg::CTRL_LAMP_OFF]),
		.err_class(fault.cls),
		.status_lamp(status_lamp)
	);

	AST_HOT_CUTS_STAGE: assert property (@(posedge clk) disable iff (reset)
		clk_en && over_temp |=> !stage_enable && fault.valid)
		else $error("power stage left on while hot");
	AST_TEMP_CLASS: assert property (@(posedge clk) disable iff (reset)
		clk_en && temp_event |=> fault.cls == fsl_pkg::CLS_TEMP)
		else $error("overtemperature not class three");
	AST_HOLD_FAULT: assert property (@(posedge clk) disable iff (reset)
		fault.valid && !fault_reset_cmd |=> fault.valid)
		else $error("fault dropped without reset command");
	AST_RESET_RESUMES: assert property (@(posedge clk) disable iff (reset)
		clk_en && clear_ok && !new_fault |=> stage_enable && !fault.valid)
		else $error("fault reset did not resume");
	AST_HISTORY_WRITE: assert property (@(posedge clk) disable iff (reset)
		clk_en && new_fault |=> history[$past(hist_ptr)] == $past(new_code))
		else $error("error code not stored");
endmodule

//--- tb/tb_top.sv
// Testbench: fault latch, register bus, interrupts and lamp sequencer
`timescale 1ns/1ps
module tb_top;
	localparam int LP = 100;
	localparam int LG = 10;
	localparam int LON = 4;
	localparam int LGAP = 6;
	localparam int LPS = 30;
	typedef struct packed {
		logic [31:0] exp;
		logic [31:0] msk;
	} fsl_exp_t;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic over_temp = 1'b0;
	logic fault_in = 1'b0;
	logic [2:0] fault_class = 3'h0;
	logic [15:0] fault_code = 16'h0;
	logic [5:0] avs_address = 6'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic stage_enable;
	logic irq;
	fsl_pkg::fsl_lamp_t status_lamp;
	fsl_exp_t exp_q[$];
	int error_cnt = 0;
	int n_tests = 0;
	integer seed = 32'h41638c19;
	int c;
	logic [15:0] code;

	always #5 clk = ~clk;

	// Short timings so whole blink groups fit into the run
	fsl_top #(.PERIOD(LP), .GREEN(LG), .RED_ON(LON), .RED_GAP(LGAP), .PAUSE(LPS)) DUT (
		.clk(clk), .reset(reset), .clk_en(clk_en), .over_temp(over_temp),
		.fault_in(fault_in), .fault_class(fault_class), .fault_code(fault_code),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .stage_enable(stage_enable), .irq(irq),
		.status_lamp(status_lamp));

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic hang(input string n);
		error_cnt++;
		$display("mismatch %s expected done seen timeout", n);
		report_and_stop();
	endtask

	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0) break;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i == 50) hang("waitrequest");
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back('{exp: e & m, msk: m});
		bus(1'b0, a, 32'h0);
	endtask

	// Read data are compared at the edge where waitrequest is sampled low
	always @(posedge clk) begin
		fsl_exp_t x;
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			if (exp_q.size() == 0) begin
				chk("unexpected read", 32'h1, 32'h0);
			end else begin
				x = exp_q.pop_front();
				chk("readdata", x.exp, avs_readdata & x.msk);
			end
		end
	end

	task automatic settle();
		repeat (3) @(posedge clk);
	endtask

	task automatic green_beat();
		int i, ph, on, per;
		logic prev, r;
		ph = 0; on = 0; per = 0; prev = 1'b1; r = 1'b0;
		for (i = 0; i < 4 * LP && ph < 3; i++) begin
			@(posedge clk);
			if (status_lamp.green === 1'b1 && !prev) ph = (ph == 1) ? 3 : 1;
			if (ph == 1) begin
				per++;
				on += (status_lamp.green === 1'b1);
			end
			r = r | status_lamp.red;
			prev = status_lamp.green;
		end
		if (ph < 3) hang("green beat");
		chk("green on time", LG, on);
		chk("green period", LP, per);
		chk("red in normal", 32'h0, 32'(r));
	endtask

	task automatic red_group(input logic [2:0] k);
		int i, ph, cnt, dark;
		logic g;
		ph = 0; cnt = 0; dark = 0; g = 1'b0;
		fault_class <= k;
		fault_in <= 1'b1;
		@(posedge clk);
		fault_in <= 1'b0;
		repeat (LPS + 6 * (LON + LGAP)) @(posedge clk);
		for (i = 0; i < 1000 && ph < 3; i++) begin
			@(posedge clk);
			g = g | status_lamp.green;
			if (status_lamp.red === 1'b1) begin
				if (ph == 2) begin
					ph = 3;
					chk("group pause long", 32'h1, 32'(dark >= 2 * LGAP));
				end else if (ph == 1 && dark > 0) cnt++;
				dark = 0;
			end else begin
				dark++;
				if (dark == LGAP + 2) ph = (ph == 0) ? 1 : ((cnt > 0) ? 2 : ph);
			end
		end
		if (ph < 3) hang("red group");
		chk("blinks per group", 32'(k), cnt);
		chk("green in error", 32'h0, 32'(g));
		bus(1'b1, 6'h00, 32'h2);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		settle();
		chk("stage_enable", 32'h1, 32'(stage_enable));
		rd(6'h04, 32'h2, 32'h7);
		over_temp <= 1'b1;
		settle();
		chk("stage_enable", 32'h0, 32'(stage_enable));
		rd(6'h04, 32'h35, 32'h77);
		rd(6'h08, 32'h4310, 32'hffff);
		rd(6'h20, 32'h4310, 32'hffff);
		bus(1'b1, 6'h00, 32'h2);
		settle();
		chk("stage_enable hot", 32'h0, 32'(stage_enable));
		over_temp <= 1'b0;
		bus(1'b1, 6'h00, 32'h2);
		settle();
		chk("stage_enable cool", 32'h1, 32'(stage_enable));
		rd(6'h04, 32'h2, 32'h7);
		$display("test overtemperature done");
		clk_en <= 1'b0;
		over_temp <= 1'b1;
		settle();
		chk("stage_enable frozen", 32'h1, 32'(stage_enable));
		over_temp <= 1'b0;
		clk_en <= 1'b1;
		@(posedge clk);
		bus(1'b1, 6'h10, 32'h3);
		bus(1'b1, 6'h14, 32'h1);
		for (c = 1; c <= 6; c++) begin
			code = 16'($random(seed));
			fault_class <= c[2:0];
			fault_code <= code;
			fault_in <= 1'b1;
			@(posedge clk);
			fault_in <= 1'b0;
			settle();
			chk("irq raised", 32'h1, 32'(irq));
			rd(6'h04, (32'(c) << 4) | 32'h1, 32'h73);
			rd(6'h08, 32'(code), 32'hffff);
			bus(1'b1, 6'h10, 32'h1);
			settle();
			chk("irq cleared", 32'h0, 32'(irq));
			bus(1'b1, 6'h00, 32'h2);
			settle();
			chk("stage_enable", 32'h1, 32'(stage_enable));
			rd(6'h0c, 32'h2, 32'h3);
			bus(1'b1, 6'h10, 32'h3);
		end
		bus(1'b1, 6'h14, 32'h0);
		fault_in <= 1'b1;
		@(posedge clk);
		fault_in <= 1'b0;
		settle();
		chk("irq masked", 32'h0, 32'(irq));
		rd(6'h0c, 32'h1, 32'h1);
		bus(1'b1, 6'h3c, 32'hffffffff);
		rd(6'h3c, 32'h0, 32'hffffffff);
		bus(1'b1, 6'h00, 32'h1);
		rd(6'h00, 32'h1, 32'h1);
		repeat (20) @(posedge clk) chk("lamp off", 32'h0, 32'(status_lamp));
		$display("test register bus and faults done");
		bus(1'b1, 6'h00, 32'h2);
		repeat (LON + 2) @(posedge clk);
		green_beat();
		for (c = 1; c <= 6; c++) red_group(c[2:0]);
		fault_class <= 3'h3;
		fault_in <= 1'b1;
		@(posedge clk);
		fault_in <= 1'b0;
		bus(1'b1, 6'h00, 32'h1);
		settle();
		repeat (3 * LP) @(posedge clk) chk("sequencer off", 32'h0, 32'(status_lamp));
		$display("test lamp sequencer done");
		report_and_stop();
	end
endmodule
